//--- src/luxr_pkg.sv
/*
  Package for the lux result and threshold register block: offsets, reset
  values, field positions and timing constants.
  Assumes a 250 MHz core clock and an I2C host on SCL/SDA pins.
*/
package luxr_pkg;
  // Register offsets
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h00; // Interrupt status
  localparam logic [7:0] OFS_IRQ_ALLOW = 8'h01; // Interrupt enable
  localparam logic [7:0] OFS_CONFIG = 8'h02; // Configuration
  localparam logic [7:0] OFS_RES_HIGH = 8'h03; // Result high byte
  localparam logic [7:0] OFS_RES_LOW = 8'h04; // Result low byte
  localparam logic [7:0] OFS_UPPER = 8'h05; // Upper trip level
  localparam logic [7:0] OFS_TIMER = 8'h07; // Threshold timer
  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h03; // Auto, 100 ms
  localparam logic [7:0] RST_UPPER = 8'hFF; // Upper trip level
  localparam logic [7:0] RST_TIMER = 8'hFF; // Threshold timer
  localparam logic [6:0] RST_SLAVE_ADDR = 7'h4A; // Slave address
  // Configuration field positions
  localparam int CFG_MANUAL_BIT = 6; // Manual ranging
  localparam int CFG_DIVIDE_BIT = 3; // Current divide
  localparam int CFG_TIME_LSB = 0; // Time select low bit
  // Result field positions
  localparam int EXP_LSB = 4; // Exponent low bit
  localparam logic [3:0] EXP_OVERRANGE = 4'hF; // Overrange exponent
  localparam logic [3:0] EXP_MAX_VALID = 4'hE; // Highest valid exponent
  localparam logic [3:0] UPPER_MANT_FILL = 4'hF; // Low mantissa fill
  // Auto ranging only picks 800/400/200/100 ms
  localparam logic [2:0] TIME_SEL_MAX_AUTO = 3'h3; // 100 ms code
  // Timing
  localparam int CLK_MHZ = 250; // Core clock rate
  localparam int TICK_MS = 100; // Persistence tick
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ; // Cycles per tick
  // Integration times in microseconds per time select code
  localparam int INTEG_US [8] = '{800000, 400000, 200000, 100000,
                                  50000, 25000, 12500, 6250};

  // Result pair carried as one struct
  typedef struct packed {
    logic [3:0] exponent; // Exponent
    logic [7:0] mantissa; // Full mantissa
  } luxr_result_t;
endpackage

//--- src/luxr_top.sv
/*
  Lux result path with I2C register slave, freeze of result registers during
  bus transactions, configuration of ranging and upper threshold interrupt.
  Assumes the converter delivers a result with a one-cycle valid strobe, and
  that SCL and SDA pass through the three-flop samplers below.
*/
`timescale 1ns/100ps
// Summary of operation
// - Auto ranging picks only 100 to 800 ms
// - Manual ranging uses programmed time select field
// - Time select codes map 800 ms to 6.25 ms
// - High byte: exponent, four high mantissa bits
// - Low byte: four low mantissa bits only
// - Exponent 1111 flags an overrange reading
// - Twelve bits give two-power times mantissa lux
// - High byte alone is coarse lux reading
// - Freeze results at valid slave address start
// - Resume result updates at next STOP
// - Upper trip byte: exponent and high mantissa
// - Upper trip counts only while enable set
// - Persistent excess sets flag, drives interrupt low
// - Upper mantissa low nibble filled with ones
// - Time and divide fields writable only manually
// - Persistence delay is timer value times 100 ms
// - Flag clears on status read or enable zero
module luxr_top import luxr_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES // Cycles per 100 ms tick
) (
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic sclIn, // SCL pin level
  input wire logic sdaIn, // SDA pin level
  output logic sdaOut, // SDA drive value (always 0)
  output logic sdaOe, // SDA drive enable
  input wire logic convValid, // Converter result strobe
  input wire luxr_result_t convResult, // Converter result
  input wire logic [2:0] autoTimeSel, // Auto ranging time choice
  input wire logic autoDivide, // Auto ranging divide choice
  output logic [2:0] integTimeSel, // Applied time select
  output logic photoCurrentDivide, // Applied current divide
  output logic manualMode, // Manual ranging active
  output logic intN // Interrupt output, active low
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA,
                ST_RACK} luxr_state_t;

  // Pin samplers, three flops each
  logic [2:0] sclSync_r; // SCL sampler
  logic [2:0] sdaSync_r; // SDA sampler
  logic sclLvl_r; // Filtered SCL
  logic sdaLvl_r; // Filtered SDA
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
      sclLvl_r <= 1'b1;
      sdaLvl_r <= 1'b1;
    end else begin
      sclSync_r <= {sclSync_r[1:0], sclIn};
      sdaSync_r <= {sdaSync_r[1:0], sdaIn};
      if (sclSync_r[1] == sclSync_r[2]) sclLvl_r <= sclSync_r[2];
      if (sdaSync_r[1] == sdaSync_r[2]) sdaLvl_r <= sdaSync_r[2];
    end
  end

  // Bus events from filtered levels
  logic sclPrev_r; // Previous SCL
  logic sdaPrev_r; // Previous SDA
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclLvl_r;
      sdaPrev_r <= sdaLvl_r;
    end
  end
  wire sclRise = sclLvl_r & ~sclPrev_r; // SCL rising
  wire sclFall = ~sclLvl_r & sclPrev_r; // SCL falling
  wire startSeen = sclLvl_r & sclPrev_r & sdaPrev_r & ~sdaLvl_r; // START or Sr
  wire stopSeen = sclLvl_r & sclPrev_r & ~sdaPrev_r & sdaLvl_r; // STOP

  // Slave state
  luxr_state_t state_r; // Protocol state
  logic [7:0] shift_r; // Shift register
  logic [3:0] bitCnt_r; // Bits taken in byte
  logic [7:0] regPtr_r; // Register pointer
  logic ptrLoaded_r; // Pointer byte taken
  logic readDir_r; // Read transaction
  logic frozen_r; // Result update hold
  logic [7:0] cfg_r; // Configuration register
  logic [7:0] upper_r; // Upper trip level
  logic [7:0] timer_r; // Threshold timer
  logic irqAllow_r; // Interrupt enable
  logic irqFlag_r; // Interrupt status
  luxr_result_t result_r; // Presented result

  // Decode of the byte just finished
  wire addrMatch = (shift_r[7:1] == RST_SLAVE_ADDR); // Our address
  wire byteDone = sclRise & (bitCnt_r == 4'h7); // Eighth bit edge
  wire [7:0] wrByte = {shift_r[6:0], sdaLvl_r}; // Byte incl. last bit
  wire wrStrobe = byteDone & (state_r == ST_WDATA) & ptrLoaded_r; // Data write
  wire ptrStrobe = byteDone & (state_r == ST_WDATA) & ~ptrLoaded_r; // Pointer
  wire rdStart = sclFall & (state_r == ST_ADDR_ACK) & readDir_r; // Load read
  wire rdNext = sclFall & (state_r == ST_RACK) & ~sdaLvl_r; // Host acked

  // Register read mux
  wire [7:0] highByte = {result_r.exponent, result_r.mantissa[7:4]};
  wire [7:0] lowByte = {4'h0, result_r.mantissa[3:0]};
  logic [7:0] rdData; // Read value
  always_comb begin
    if (regPtr_r == OFS_IRQ_FLAG) rdData = {7'h00, irqFlag_r};
    else if (regPtr_r == OFS_IRQ_ALLOW) rdData = {7'h00, irqAllow_r};
    else if (regPtr_r == OFS_CONFIG) rdData = {cfg_r[7:4], photoCurrentDivide, integTimeSel};
    else if (regPtr_r == OFS_RES_HIGH) rdData = highByte;
    else if (regPtr_r == OFS_RES_LOW) rdData = lowByte;
    else if (regPtr_r == OFS_UPPER) rdData = upper_r;
    else if (regPtr_r == OFS_TIMER) rdData = timer_r;
    else rdData = 8'h00;
  end
  wire statusRead = (rdStart | rdNext) & (regPtr_r == OFS_IRQ_FLAG);

  // Protocol state machine
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      bitCnt_r <= 4'h0;
      ptrLoaded_r <= 1'b0;
      readDir_r <= 1'b0;
    end else if (stopSeen) begin
      state_r <= ST_IDLE;
    end else if (startSeen) begin
      state_r <= ST_ADDR;
      bitCnt_r <= 4'h0;
      ptrLoaded_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_WDATA: begin
          if (sclRise) begin
            shift_r <= wrByte;
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          if (sclFall && bitCnt_r == 4'h8) begin
            bitCnt_r <= 4'h0;
            if (state_r == ST_WDATA) begin
              state_r <= ST_WACK;
              ptrLoaded_r <= 1'b1;
            end else if (addrMatch) begin
              state_r <= ST_ADDR_ACK;
              readDir_r <= shift_r[0];
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_WACK: begin
          if (sclFall) state_r <= readDir_r ? ST_RDATA : ST_WDATA;
          if (sclFall && readDir_r) shift_r <= rdData;
        end
        ST_RDATA: begin
          if (sclFall) begin
            shift_r <= {shift_r[6:0], 1'b0};
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == 4'h7) state_r <= ST_RACK;
          end
        end
        ST_RACK: begin
          if (sclFall) begin
            bitCnt_r <= 4'h0;
            state_r <= sdaLvl_r ? ST_IDLE : ST_RDATA;
            shift_r <= rdData;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Pointer and write registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      regPtr_r <= 8'h00;
      cfg_r <= RST_CONFIG;
      upper_r <= RST_UPPER;
      timer_r <= RST_TIMER;
    end else begin
      if (ptrStrobe) regPtr_r <= wrByte;
      // Post-increment once each read byte is loaded, so the next byte is the next register
      else if (wrStrobe || rdStart || rdNext) regPtr_r <= regPtr_r + 8'h01;
      if (wrStrobe && regPtr_r == OFS_CONFIG) cfg_r <= wrByte;
      if (wrStrobe && regPtr_r == OFS_UPPER) upper_r <= wrByte;
      if (wrStrobe && regPtr_r == OFS_TIMER) timer_r <= wrByte;
    end
  end

  // SDA drive: ack and read data, open drain
  wire ackDrive = (state_r == ST_ADDR_ACK) | (state_r == ST_WACK); // Ack slot
  wire rdDrive = (state_r == ST_RDATA) & ~shift_r[7]; // Zero bit
  always_ff @(posedge core_clk) begin
    if (!resetn) sdaOe <= 1'b0;
    else sdaOe <= ackDrive | rdDrive;
  end
  assign sdaOut = 1'b0;

  // Ranging selection; fields follow auto choice unless manual
  assign manualMode = cfg_r[CFG_MANUAL_BIT];
  wire [2:0] autoClamped = (autoTimeSel > TIME_SEL_MAX_AUTO) ? TIME_SEL_MAX_AUTO
                          : autoTimeSel;
  assign integTimeSel = manualMode ? cfg_r[CFG_TIME_LSB +: 3] : autoClamped;
  assign photoCurrentDivide = manualMode ? cfg_r[CFG_DIVIDE_BIT] : autoDivide;

  // Result update with freeze between address and STOP
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      frozen_r <= 1'b0;
      result_r <= '0;
    end else begin
      if (sclFall && state_r == ST_ADDR && bitCnt_r == 4'h8 && addrMatch)
        frozen_r <= 1'b1;
      else if (stopSeen) frozen_r <= 1'b0;
      if (convValid && !frozen_r) result_r <= convResult;
    end
  end

  // Linear magnitudes of reading and threshold
  wire [22:0] readLin = 23'(result_r.mantissa) << result_r.exponent;
  wire [7:0] upperMant = {upper_r[3:0], UPPER_MANT_FILL};
  wire [22:0] upperLin = 23'(upperMant) << upper_r[7:EXP_LSB];
  wire over = (result_r.exponent == EXP_OVERRANGE) | (readLin > upperLin);

  // Persistence timer in 100 ms ticks
  logic [31:0] tickCnt_r; // Cycles in tick
  logic [7:0] tickNum_r; // Ticks above level
  wire tickEnd = (tickCnt_r == 32'(TICK_LEN - 1)); // Tick boundary
  wire persisted = over & ((timer_r == 8'h00) | (tickNum_r >= timer_r));
  always_ff @(posedge core_clk) begin
    if (!resetn || !over || !irqAllow_r) begin
      tickCnt_r <= 32'h0;
      tickNum_r <= 8'h00;
    end else begin
      tickCnt_r <= tickEnd ? 32'h0 : tickCnt_r + 32'h1;
      if (tickEnd && tickNum_r != 8'hFF) tickNum_r <= tickNum_r + 8'h01;
    end
  end

  // Interrupt enable and flag; set wins over clear
  wire allowWr = wrStrobe & (regPtr_r == OFS_IRQ_ALLOW); // Enable write
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irqAllow_r <= 1'b0;
      irqFlag_r <= 1'b0;
    end else begin
      if (allowWr) irqAllow_r <= wrByte[0];
      if (irqAllow_r && persisted) irqFlag_r <= 1'b1;
      else if (statusRead || (allowWr && !wrByte[0])) irqFlag_r <= 1'b0;
    end
  end
  assign intN = ~irqFlag_r;

  // Checks
  AST_FREEZE_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    frozen_r && !$past(stopSeen) |=> $stable(result_r) || $past(!frozen_r))
    else $error("Result changed while frozen");
  AST_STOP_RELEASE: assert property (@(posedge core_clk) disable iff (!resetn)
    stopSeen |=> !frozen_r) else $error("Freeze not released at STOP");
  AST_AUTO_RANGE: assert property (@(posedge core_clk) disable iff (!resetn)
    !manualMode |-> integTimeSel <= TIME_SEL_MAX_AUTO) else $error("Auto time out of set");
  AST_MANUAL_TIME: assert property (@(posedge core_clk) disable iff (!resetn)
    manualMode |-> integTimeSel == cfg_r[2:0]) else $error("Manual time not applied");
  // Loads of the result bytes into the read shifter
  sequence s_loadHigh;
    (rdStart || rdNext) && regPtr_r == OFS_RES_HIGH;
  endsequence
  sequence s_loadLow;
    (rdStart || rdNext) && regPtr_r == OFS_RES_LOW;
  endsequence
  AST_LOW_NIBBLE: assert property (@(posedge core_clk) disable iff (!resetn)
    s_loadLow |=> shift_r[7:4] == 4'h0) else $error("Low byte upper bits set");
  AST_INT_PIN: assert property (@(posedge core_clk) disable iff (!resetn)
    intN == !irqFlag_r) else $error("Interrupt pin mismatch");
  AST_NO_IRQ_DISABLED: assert property (@(posedge core_clk) disable iff (!resetn)
    !irqAllow_r && !irqFlag_r |=> !irqFlag_r) else $error("Flag set while disabled");
  AST_SET_ON_PERSIST: assert property (@(posedge core_clk) disable iff (!resetn)
    irqAllow_r && persisted |=> irqFlag_r) else $error("Flag not set");
  AST_CLEAR_READ: assert property (@(posedge core_clk) disable iff (!resetn)
    statusRead && !(irqAllow_r && persisted) |=> !irqFlag_r) else $error("Flag not cleared");
  AST_HIGH_BYTE: assert property (@(posedge core_clk) disable iff (!resetn)
    s_loadHigh |=> shift_r == $past(highByte)) else $error("High byte load wrong");
endmodule

//--- verif/luxr_host.sv
/*
  I2C host model for the lux register block: START, repeated START, STOP and byte
  transfers on a 64 ns link period.
  Assumes the bench resolves SDA with a pull-up and feeds SCL to the device.
*/
`timescale 1ns/100ps
module luxr_host import luxr_pkg::*; (
  output logic scl, // SCL level, idle high
  output logic sdaLow, // High while host pulls SDA low
  input wire logic sda // Resolved SDA level
);
  // Bus idle at time zero
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Quarter of the link period
  task automatic q();
    #16;
  endtask
  // One bit, data set with SCL low, sampled with SCL high
  task automatic bitx(input logic b, output logic s);
    q();
    sdaLow = !b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
  endtask
  // START, and repeated START from SCL low
  task automatic start();
    q();
    sdaLow = 1'b0;
    q();
    scl = 1'b1;
    q();
    sdaLow = 1'b1;
    q();
    scl = 1'b0;
  endtask
  // STOP, leaves SCL standing high
  task automatic stop();
    q();
    sdaLow = 1'b1;
    q();
    scl = 1'b1;
    q();
    sdaLow = 1'b0;
    q();
  endtask
  // Eight bits MSB first plus acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r[i]);
    end
    bitx(ai, ao);
  endtask
  // Register write; ack is high if the address byte was refused
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic k;
    start();
    xfer({RST_SLAVE_ADDR, 1'b0}, 1'b1, r, ack);
    xfer(p, 1'b1, r, k);
    xfer(d, 1'b1, r, k);
    stop();
  endtask
  // Pointer write, repeated START, n bytes read, one STOP at the end
  task automatic rd(input logic [6:0] ad, input logic [7:0] p, input int n,
                    output logic [31:0] v, output logic ack);
    logic [7:0] r;
    logic k;
    v = '0;
    start();
    xfer({ad, 1'b0}, 1'b1, r, ack);
    xfer(p, 1'b1, r, k);
    start();
    xfer({ad, 1'b1}, 1'b1, r, k);
    ack = ack | k;
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, r, k);
      v[8*i+:8] = r;
    end
    stop();
  endtask
endmodule

//--- verif/test_lux_result_and_threshold_regs.sv
/*
  Self-checking bench for the lux result block: ranging, result bytes, freeze,
  upper trip level and persistence.
  Assumes the host model partner and a shortened persistence tick.
*/
`timescale 1ns/100ps
module test_lux_result_and_threshold_regs;
  import luxr_pkg::*;
  localparam int TICK = 10; // Short tick
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic sclIn, hostLow, sdaOut, sdaOe, photoCurrentDivide, manualMode, intN, a;
  logic convValid = 1'b0;
  logic autoDivide = 1'b0;
  logic [2:0] autoTimeSel = 3'h3;
  logic [2:0] integTimeSel;
  luxr_result_t convResult = '0;
  logic [11:0] mRes = '0; // Model of stored result
  logic [31:0] v;
  logic [31:0] rng = 32'h5C;
  logic [11:0] tbl [5] = '{12'h01F, 12'h020, 12'h110, 12'hF00, 12'h01E};
  int miscompares = 0;
  int checks_done = 0;
  int n;
  wire logic sdaIn = hostLow ? 1'b0 : (sdaOe ? sdaOut : 1'b1); // Pull-up
  luxr_top #(.TICK_LEN(TICK)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .convValid(convValid), .convResult(convResult), .autoTimeSel(autoTimeSel),
    .autoDivide(autoDivide), .integTimeSel(integTimeSel),
    .photoCurrentDivide(photoCurrentDivide), .manualMode(manualMode), .intN(intN));
  luxr_host i_host (.scl(sclIn), .sdaLow(hostLow), .sda(sdaIn));
  // Core clock
  always #2 core_clk = ~core_clk;
  // Random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Model: reading above expanded trip level
  function automatic logic over(input logic [11:0] r, input logic [7:0] u);
    longint lr;
    longint lu;
    lr = longint'(r[7:0]) << r[11:8];
    lu = longint'({u[3:0], 4'hF}) << u[7:4];
    return r[11:8] == 4'hF || lr > lu;
  endfunction
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Converter strobe; model follows when not frozen
  task automatic conv(input logic [11:0] x, input logic upd);
    @(posedge core_clk) #1;
    convResult = x;
    convValid = 1'b1;
    @(posedge core_clk) #1;
    convValid = 1'b0;
    if (upd) mRes = x;
  endtask
  // Coherent pair read of both result bytes
  task automatic chk_res();
    logic [31:0] w;
    logic k;
    i_host.rd(RST_SLAVE_ADDR, OFS_RES_HIGH, 2, w, k);
    chk("res high", mRes[11:4], w[7:0]);
    chk("res low", {4'h0, mRes[3:0]}, w[15:8]);
  endtask
  // Hang guard
  initial begin
    #300000;
    miscompares++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (8) @(posedge core_clk) #1;
    i_host.rd(RST_SLAVE_ADDR, OFS_UPPER, 1, v, a);
    chk("upper rst", RST_UPPER, v[7:0]);
    // Auto ranging, writes to time fields ignored
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      i_host.wr(OFS_CONFIG, 8'h0F, a);
      @(posedge core_clk) #1;
      autoTimeSel = 3'(k);
      autoDivide = rng[0];
      #1;
      chk("auto sel", (k > 3) ? 8'h3 : 8'(k), {5'h0, integTimeSel});
      chk("auto div", {7'h0, rng[0]}, {7'h0, photoCurrentDivide});
    end
    // Manual ranging, every time code
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      autoTimeSel = rng[3:1];
      i_host.wr(OFS_CONFIG, {4'h4, rng[0], 3'(k)}, a);
      @(posedge core_clk) #1;
      chk("man sel", 8'(k), {5'h0, integTimeSel});
      chk("man div", {7'h0, rng[0]}, {7'h0, photoCurrentDivide});
      chk("manual", 8'h1, {7'h0, manualMode});
    end
    // Results, overrange and full scale first
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      conv((k == 0) ? {4'hF, rng[7:0]} : (k == 1) ? 12'hEFF : rng[11:0], 1'b1);
      chk_res();
    end
    // New result during a pair read is held off, then updates resume
    fork
      chk_res();
      begin
        #1200;
        conv(12'h5A5, 1'b0);
      end
    join
    conv(12'h3C3, 1'b1);
    chk_res();
    i_host.wr(OFS_RES_HIGH, 8'h00, a);
    chk_res();
    i_host.rd(RST_SLAVE_ADDR ^ 7'h01, OFS_RES_HIGH, 1, v, a);
    chk("nack", 8'h1, {7'h0, a});
    // Upper trip level, disabled then enabled
    i_host.wr(OFS_TIMER, 8'h00, a);
    i_host.wr(OFS_UPPER, 8'h01, a);
    conv(12'h020, 1'b1);
    repeat (20) @(posedge core_clk) #1;
    chk("int off", 8'h1, {7'h0, intN});
    foreach (tbl[i]) begin
      i_host.wr(OFS_IRQ_ALLOW, 8'h00, a);
      conv(tbl[i], 1'b1);
      // Set wins at the disabling write; a status read while disabled clears
      i_host.rd(RST_SLAVE_ADDR, OFS_IRQ_FLAG, 1, v, a);
      i_host.wr(OFS_IRQ_ALLOW, 8'h01, a);
      repeat (4) @(posedge core_clk) #1;
      chk("int", {7'h0, !over(mRes, 8'h01)}, {7'h0, intN});
    end
    // Sticky flag cleared by status read
    conv(12'h020, 1'b1);
    repeat (4) @(posedge core_clk) #1;
    chk("int set", 8'h0, {7'h0, intN});
    conv(12'h00F, 1'b1);
    i_host.rd(RST_SLAVE_ADDR, OFS_IRQ_FLAG, 1, v, a);
    chk("flag", 8'h1, {7'h0, v[0]});
    chk("int clr", 8'h1, {7'h0, intN});
    // Persistence of two ticks
    i_host.wr(OFS_TIMER, 8'h02, a);
    conv(12'h020, 1'b1);
    n = 0;
    while (intN !== 1'b0 && n < 200) begin
      @(posedge core_clk) #1;
      n++;
    end
    chk("delay", 8'h1, {7'h0, n >= 2 * TICK && n <= 2 * TICK + 4});
    close_out();
  end
endmodule
